// *** core/sdfr_pkg.sv ***
package sdfr_pkg;
    // command codes
    localparam logic [7:0] OPC_DUAL_EDGE_FAST_READ = 8'h0D;
    localparam logic [7:0] OPC_DUAL_EDGE_FAST_READ_WIDE = 8'h0E;

    // phase lengths held as last index: opcode in rising edges, address and mode in link edges; preamble as an edge count
    localparam logic [5:0] OPC_LAST = 6'h07;
    localparam logic [5:0] ADDR_LAST_NARROW = 6'h17;
    localparam logic [5:0] ADDR_LAST_WIDE = 6'h1F;
    localparam logic [5:0] MODE_LAST = 6'h07;
    localparam logic [5:0] PREAMBLE_EDGES = 6'h08;

    // phase lengths in link edges, host view
    localparam logic [7:0] OPC_EDGES = 8'h10;
    localparam logic [7:0] ADDR_EDGES_NARROW = 8'h18;
    localparam logic [7:0] ADDR_EDGES_WIDE = 8'h20;
    localparam logic [7:0] MODE_EDGES = 8'h08;

    // learning preamble value after reset of a bench strap
    localparam logic [7:0] PREAMBLE_RST = 8'h34;

    // highest array byte address; plain default, wraps to zero
    localparam logic [31:0] ARRAY_TOP = 32'h00FF_FFFF;

    // latency code to dummy clock cycles
    localparam logic [5:0] LAT_CYC_LC0 = 6'h05;
    localparam logic [5:0] LAT_CYC_LC1 = 6'h06;
    localparam logic [5:0] LAT_CYC_LC2 = 6'h07;
    localparam logic [5:0] LAT_CYC_LC3 = 6'h08;

    // link clock limit and host divider
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCK_MIN_PERIOD_PS = 12500;
    localparam int SCK_MIN_HALF_CYC = (SCK_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1)
                                      / (2 * CLK_PERIOD_PS);
    localparam int HOST_HALF_WANT = 8;
    localparam int HOST_HALF_CYC = (HOST_HALF_WANT > SCK_MIN_HALF_CYC) ?
                                   HOST_HALF_WANT : SCK_MIN_HALF_CYC;
    localparam logic [3:0] HALF_LAST = 4'(HOST_HALF_CYC - 1);
    localparam logic [3:0] HALF_MID = 4'(HOST_HALF_CYC / 2 - 1);

    // host register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_RDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTL_GO = 0;
    localparam int CTL_WIDE_CMD = 1;
    localparam int CTL_WIDE_ADDR = 2;
    localparam int CTL_ENH = 3;
    localparam int CTL_SKIP_OPC = 4;
    localparam int CTL_LC_LSB = 6;
    localparam int CTL_MODE_LSB = 8;
    localparam int CTL_CNT_LSB = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0003_FFDE;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_PRE_LSB = 8;

    typedef enum logic [6:0] {
        M_IDLE = 7'h01,
        M_OPC = 7'h02,
        M_ADDR = 7'h04,
        M_MODE = 7'h08,
        M_DUMMY = 7'h10,
        M_DATA = 7'h20,
        M_SKIP = 7'h40
    } sdfr_mem_state_e;

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_LOAD = 5'h02,
        H_SETUP = 5'h04,
        H_RUN = 5'h08,
        H_TAIL = 5'h10
    } sdfr_host_state_e;

    // dummy edges: two per latency clock
    function automatic logic [5:0] dummy_edges(input logic [1:0] lc);
        logic [5:0] cyc;
        case (lc)
            2'h0: cyc = LAT_CYC_LC0;
            2'h1: cyc = LAT_CYC_LC1;
            2'h2: cyc = LAT_CYC_LC2;
            default: cyc = LAT_CYC_LC3;
        endcase
        return {cyc[4:0], 1'b0};
    endfunction
endpackage

// *** core/sdfr_link_if.sv ***
interface sdfr_link_if;
    logic sck;
    logic cs_n;
    logic si_drv;
    logic si_oe;
    logic so_drv;
    logic so_oe;
    logic si;
    logic so;

    // released lines float high
    assign si = si_oe ? si_drv : 1'b1;
    assign so = so_oe ? so_drv : 1'b1;

    modport host (output sck, output cs_n, output si_drv, output si_oe, input so);
    modport mem (input sck, input cs_n, input si, output so_drv, output so_oe);
endinterface

// *** core/sdfr_mem.sv ***
// Chosen here: register access over AHB-Lite and the address map.
module sdfr_mem (
    // system
    input wire logic I_CLK,
    input wire logic I_SRST,
    // serial link
    sdfr_link_if.mem LINK,
    // configuration
    input wire logic I_WIDE_ADDRESS_SELECT,
    input wire logic I_ENHANCED_LATENCY_TABLE,
    input wire logic [1:0] I_LATENCY_CODE_FIELD,
    input wire logic I_LEARNING_PREAMBLE_EN,
    input wire logic [7:0] I_LEARNING_PREAMBLE,
    input wire logic I_HOLD_N,
    // array read port
    output logic [31:0] O_RD_ADDR,
    input wire logic [7:0] I_RD_DATA,
    // status
    output logic O_CONT_MODE,
    output logic O_FRAME_ACTIVE
);
    logic [2:0] sck_q;
    logic [2:0] cs_q;
    logic [1:0] si_q;
    sdfr_pkg::sdfr_mem_state_e state;
    sdfr_pkg::sdfr_mem_state_e next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [31:0] shreg;
    logic [31:0] next_shreg;
    logic [7:0] mode_sr;
    logic [7:0] next_mode_sr;
    logic [6:0] osr;
    logic [6:0] next_osr;
    logic [2:0] bcnt;
    logic [2:0] next_bcnt;
    logic [31:0] next_addr;
    logic wide;
    logic next_wide;
    logic mode_done;
    logic next_mode_done;
    logic next_cont;
    logic so;
    logic next_so;
    logic so_oe;
    logic next_so_oe;

    // edge finding on the synchronised link pins
    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire sck_fall = ~sck_q[1] & sck_q[2];
    wire sck_edge = sck_rise | sck_fall;
    wire cs_fall = ~cs_q[1] & cs_q[2];
    wire cs_rise = cs_q[1] & ~cs_q[2];
    wire si_bit = si_q[1];

    // decode of what has been shifted in
    wire [7:0] opc_in = {shreg[6:0], si_bit};
    wire [31:0] addr_in = wide ? {shreg[30:0], si_bit} : {8'h00, shreg[22:0], si_bit};
    wire [5:0] addr_last = wide ? sdfr_pkg::ADDR_LAST_WIDE : sdfr_pkg::ADDR_LAST_NARROW;
    // the falling edge right after the opcode carries nothing
    wire addr_take = sck_rise | (sck_fall & (cnt != 6'h00));
    wire mode_cmp = mode_sr[7:4] == ~mode_sr[3:0];

    // latency position
    wire [5:0] dummy_n = cnt + 6'h01;
    wire [5:0] data_start = sdfr_pkg::dummy_edges(I_LATENCY_CODE_FIELD);
    wire [5:0] pre_start = data_start - sdfr_pkg::PREAMBLE_EDGES;

    // byte address stepping
    wire at_top = O_RD_ADDR >= sdfr_pkg::ARRAY_TOP;
    wire [31:0] addr_step = at_top ? 32'h0000_0000 : O_RD_ADDR + 32'h0000_0001;

    // hold pin is never looked at: this command runs straight through
    wire hold_unused = I_HOLD_N;

    assign LINK.so_drv = so;
    assign LINK.so_oe = so_oe;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_mode_sr = mode_sr;
        next_osr = osr;
        next_bcnt = bcnt;
        next_addr = O_RD_ADDR;
        next_wide = wide;
        next_mode_done = mode_done;
        next_cont = O_CONT_MODE;
        next_so = so;
        next_so_oe = so_oe;
        if (cs_rise) begin
            next_state = sdfr_pkg::M_IDLE;
            // only a whole, complementary mode byte keeps the opcode away
            next_cont = mode_done & mode_cmp;
            next_mode_done = 1'b0;
            next_so_oe = 1'b0;
        end else if (cs_fall) begin
            next_state = O_CONT_MODE ? sdfr_pkg::M_ADDR : sdfr_pkg::M_OPC;
            next_cnt = 6'h00;
        end else if (sck_edge) begin
            case (state)
                sdfr_pkg::M_OPC: begin
                    if (sck_rise) begin
                        next_shreg = {shreg[30:0], si_bit};
                        next_cnt = cnt + 6'h01;
                        if (cnt == sdfr_pkg::OPC_LAST) begin
                            next_cnt = 6'h00;
                            next_state = sdfr_pkg::M_ADDR;
                            if (opc_in == sdfr_pkg::OPC_DUAL_EDGE_FAST_READ) begin
                                next_wide = I_WIDE_ADDRESS_SELECT;
                            end else if (opc_in == sdfr_pkg::OPC_DUAL_EDGE_FAST_READ_WIDE) begin
                                next_wide = 1'b1;
                            end else begin
                                next_state = sdfr_pkg::M_SKIP;
                            end
                        end
                    end
                end
                sdfr_pkg::M_ADDR: begin
                    if (addr_take) begin
                        next_shreg = {shreg[30:0], si_bit};
                        next_cnt = cnt + 6'h01;
                        if (cnt == addr_last) begin
                            next_addr = addr_in;
                            next_cnt = 6'h00;
                            if (I_ENHANCED_LATENCY_TABLE) begin
                                next_state = sdfr_pkg::M_MODE;
                            end else begin
                                next_state = sdfr_pkg::M_DUMMY;
                            end
                        end
                    end
                end
                sdfr_pkg::M_MODE: begin
                    next_mode_sr = {mode_sr[6:0], si_bit};
                    next_cnt = cnt + 6'h01;
                    if (cnt == sdfr_pkg::MODE_LAST) begin
                        next_cnt = 6'h00;
                        next_mode_done = 1'b1;
                        next_state = sdfr_pkg::M_DUMMY;
                    end
                end
                sdfr_pkg::M_DUMMY: begin
                    // input line not sampled here
                    next_cnt = dummy_n;
                    if (dummy_n == data_start) begin
                        next_state = sdfr_pkg::M_DATA;
                        next_so = I_RD_DATA[7];
                        next_osr = I_RD_DATA[6:0];
                        next_bcnt = 3'h1;
                        next_so_oe = 1'b1;
                    end else if (dummy_n == pre_start) begin
                        next_so = I_LEARNING_PREAMBLE[7];
                        next_osr = I_LEARNING_PREAMBLE[6:0];
                        next_so_oe = I_LEARNING_PREAMBLE_EN;
                    end else if (dummy_n > pre_start) begin
                        next_so = osr[6];
                        next_osr = {osr[5:0], 1'b0};
                    end
                end
                sdfr_pkg::M_DATA: begin
                    next_bcnt = bcnt + 3'h1;
                    if (bcnt == 3'h0) begin
                        // next byte fetched at its first bit, address moved one edge before, at the last bit of the previous byte
                        next_so = I_RD_DATA[7];
                        next_osr = I_RD_DATA[6:0];
                    end else begin
                        next_so = osr[6];
                        next_osr = {osr[5:0], 1'b0};
                    end
                    if (bcnt == 3'h7) begin
                        next_addr = addr_step;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    // link pins cross in through two flops each
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            sck_q <= 3'h0;
            cs_q <= 3'h7;
            si_q <= 2'h0;
        end else begin
            sck_q <= {sck_q[1:0], LINK.sck};
            cs_q <= {cs_q[1:0], LINK.cs_n};
            si_q <= {si_q[0], LINK.si};
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state <= sdfr_pkg::M_IDLE;
            cnt <= 6'h00;
            shreg <= 32'h0000_0000;
            mode_sr <= 8'h00;
            osr <= 7'h00;
            bcnt <= 3'h0;
            O_RD_ADDR <= 32'h0000_0000;
            wide <= 1'b0;
            mode_done <= 1'b0;
            O_CONT_MODE <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            mode_sr <= next_mode_sr;
            osr <= next_osr;
            bcnt <= next_bcnt;
            O_RD_ADDR <= next_addr;
            wide <= next_wide;
            mode_done <= next_mode_done;
            O_CONT_MODE <= next_cont;
            so <= next_so;
            so_oe <= next_so_oe;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_FRAME_ACTIVE <= 1'b0;
        end else begin
            O_FRAME_ACTIVE <= (next_state != sdfr_pkg::M_IDLE) & ~hold_unused | 
                              (next_state != sdfr_pkg::M_IDLE);
        end
    end
endmodule

// *** core/sdfr_host.sv ***
module sdfr_host (
    // system
    input wire logic I_CLK,
    input wire logic I_SRST,
    // register bus
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // serial link
    sdfr_link_if.host LINK
);
    sdfr_pkg::sdfr_host_state_e state;
    logic [31:0] ctrl;
    logic [31:0] addr_reg;
    logic [31:0] rdata;
    logic [7:0] pre;
    logic done;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [1:0] so_q;
    logic [3:0] hc;
    logic [7:0] tc;
    logic [7:0] opc_e;
    logic [7:0] e0;
    logic [7:0] lat;
    logic [7:0] tot;
    logic [47:0] sr;
    logic sck;
    logic cs_n;
    logic si;
    logic si_oe;

    // bus decode; whole-word transfers only
    wire idle = state == sdfr_pkg::H_IDLE;
    wire ap_sel = I_HSEL & I_HTRANS[1] & I_HREADY;
    wire wr_ctrl = ap_wr & (ap_addr == sdfr_pkg::REG_CTRL) & idle;
    wire wr_addr = ap_wr & (ap_addr == sdfr_pkg::REG_ADDR) & idle;
    wire wr_stat = ap_wr & (ap_addr == sdfr_pkg::REG_STATUS);
    wire go = wr_ctrl & I_HWDATA[sdfr_pkg::CTL_GO];
    wire [31:0] status = {16'h0000, pre, 6'h00, done, ~idle};
    wire [31:0] rd_mux = (I_HADDR[7:0] == sdfr_pkg::REG_CTRL) ? ctrl :
                         (I_HADDR[7:0] == sdfr_pkg::REG_ADDR) ? addr_reg :
                         (I_HADDR[7:0] == sdfr_pkg::REG_RDATA) ? rdata :
                         (I_HADDR[7:0] == sdfr_pkg::REG_STATUS) ? status : 32'h0000_0000;

    // frame shape from the control word
    wire c_wide_cmd = ctrl[sdfr_pkg::CTL_WIDE_CMD];
    wire wide_sel = c_wide_cmd | ctrl[sdfr_pkg::CTL_WIDE_ADDR];
    wire c_skip = ctrl[sdfr_pkg::CTL_SKIP_OPC];
    wire [7:0] mode = ctrl[sdfr_pkg::CTL_MODE_LSB +: 8];
    wire [2:0] nbytes = {1'b0, ctrl[sdfr_pkg::CTL_CNT_LSB +: 2]} + 3'h1;
    wire [7:0] opc = c_wide_cmd ? sdfr_pkg::OPC_DUAL_EDGE_FAST_READ_WIDE :
                                  sdfr_pkg::OPC_DUAL_EDGE_FAST_READ;
    wire [7:0] f_opc_e = c_skip ? 8'h00 : sdfr_pkg::OPC_EDGES;
    wire [7:0] f_alen = wide_sel ? sdfr_pkg::ADDR_EDGES_WIDE : sdfr_pkg::ADDR_EDGES_NARROW;
    wire [7:0] f_mode_e = ctrl[sdfr_pkg::CTL_ENH] ? sdfr_pkg::MODE_EDGES : 8'h00;
    wire [7:0] f_lat = {2'h0, sdfr_pkg::dummy_edges(ctrl[sdfr_pkg::CTL_LC_LSB +: 2])};
    wire [7:0] f_e0 = f_opc_e + f_alen + f_mode_e;
    wire [47:0] seq = wide_sel ? {opc, addr_reg, mode} : {opc, addr_reg[23:0], mode, 8'h00};

    // edge bookkeeping while running
    wire [7:0] n = tc + 8'h01;
    wire [7:0] m = n - e0;
    wire present = (n <= opc_e) ? n[0] : (n <= e0);
    wire cap_pre = (n > e0) & (m + 8'h07 >= lat) & (m <= lat);
    wire cap_dat = (n > e0 + lat) & (n <= tot);
    wire half_end = hc == sdfr_pkg::HALF_LAST;

    assign LINK.sck = sck;
    assign LINK.cs_n = cs_n;
    assign LINK.si_drv = si;
    assign LINK.si_oe = si_oe;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ap_wr <= 1'b0;
            ap_addr <= 8'h00;
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            ctrl <= sdfr_pkg::CTRL_RST;
            addr_reg <= 32'h0000_0000;
            done <= 1'b0;
            so_q <= 2'h3;
        end else begin
            ap_wr <= ap_sel & I_HWRITE;
            ap_addr <= I_HADDR[7:0];
            O_HRDATA <= (ap_sel & ~I_HWRITE) ? rd_mux : 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            so_q <= {so_q[0], LINK.so};
            if (wr_ctrl) begin
                ctrl <= I_HWDATA & sdfr_pkg::CTRL_MASK;
            end
            if (wr_addr) begin
                addr_reg <= I_HWDATA;
            end
            // completion beats a clear in the same cycle
            if ((state == sdfr_pkg::H_TAIL) & half_end) begin
                done <= 1'b1;
            end else if (go | (wr_stat & I_HWDATA[sdfr_pkg::ST_DONE])) begin
                done <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state <= sdfr_pkg::H_IDLE;
            hc <= 4'h0;
            tc <= 8'h00;
            opc_e <= 8'h00;
            e0 <= 8'h00;
            lat <= 8'h00;
            tot <= 8'h00;
            sr <= 48'h0;
            rdata <= 32'h0000_0000;
            pre <= 8'h00;
            sck <= 1'b0;
            cs_n <= 1'b1;
            si <= 1'b0;
            si_oe <= 1'b0;
        end else begin
            hc <= half_end ? 4'h0 : hc + 4'h1;
            case (state)
                sdfr_pkg::H_IDLE: begin
                    if (go) begin
                        state <= sdfr_pkg::H_LOAD;
                    end
                end
                sdfr_pkg::H_LOAD: begin
                    opc_e <= f_opc_e;
                    e0 <= f_e0;
                    lat <= f_lat;
                    tot <= f_e0 + f_lat + {2'h0, nbytes, 3'h0};
                    sr <= c_skip ? {seq[39:0], 8'h00} : seq;
                    tc <= 8'h00;
                    rdata <= 32'h0000_0000;
                    cs_n <= 1'b0;
                    si_oe <= 1'b1;
                    hc <= 4'h0;
                    state <= sdfr_pkg::H_SETUP;
                end
                sdfr_pkg::H_SETUP: begin
                    if (half_end) begin
                        state <= sdfr_pkg::H_RUN;
                    end
                end
                sdfr_pkg::H_RUN: begin
                    if (hc == sdfr_pkg::HALF_MID) begin
                        if (present) begin
                            si <= sr[47];
                            sr <= {sr[46:0], 1'b0};
                        end
                        if (n > e0) begin
                            si_oe <= 1'b0;
                        end
                    end
                    if (half_end) begin
                        sck <= ~sck;
                        tc <= n;
                        if (cap_pre) begin
                            pre <= {pre[6:0], so_q[1]};
                        end
                        if (cap_dat) begin
                            rdata <= {rdata[30:0], so_q[1]};
                        end
                        if (n == tot) begin
                            state <= sdfr_pkg::H_TAIL;
                        end
                    end
                end
                sdfr_pkg::H_TAIL: begin
                    if (half_end) begin
                        cs_n <= 1'b1;
                        state <= sdfr_pkg::H_IDLE;
                    end
                end
                default: begin
                    state <= sdfr_pkg::H_IDLE;
                end
            endcase
        end
    end
endmodule

// *** sim/sdfr_link_sva.sv ***
module sdfr_link_sva (
    // system
    input wire logic I_CLK,
    input wire logic I_SRST,
    // link lines
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si_oe,
    input wire logic i_so_drv,
    input wire logic i_so_oe
);
    logic sck_q;
    logic [7:0] ecnt;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // link edges seen in the current frame
    always_ff @(posedge I_CLK) begin
        sck_q <= i_sck;
        if (I_SRST || i_cs_n) ecnt <= 8'h00;
        else if (i_sck != sck_q) ecnt <= ecnt + 8'h01;
    end
    sck_idle_low_a: assert property (i_cs_n |-> !i_sck)
        else $error("link clock high while deselected");
    sck_half_a: assert property ($changed(i_sck) |=> $stable(i_sck) [*7])
        else $error("link clock half period too short");
    no_fight_a: assert property (!(i_si_oe && i_so_oe))
        else $error("both ends drive the lines");
    si_in_frame_a: assert property (i_si_oe |-> !i_cs_n)
        else $error("input line driven outside a frame");
    so_release_a: assert property (i_cs_n [*6] |-> !i_so_oe)
        else $error("output line held after deselect");
    so_late_a: assert property ($rose(i_so_oe) |-> ecnt >= 8'd26)
        else $error("output driven before address done");
    frame_whole_a: assert property ($rose(i_cs_n) |-> !i_sck && !ecnt[0])
        else $error("frame closed on a half clock");
    // settle margin covers the memory's sync delay
    so_hold_a: assert property ($stable(i_sck) [*6] ##0 (i_so_oe && !i_cs_n) |->
        $stable(i_so_drv)) else $error("output bit moved between edges");
endmodule

// *** sim/spi_ddr_fast_read_tb_top.sv ***
module spi_ddr_fast_read_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] CTRL_T [7] = '{32'h0003_0000, 32'h0003_0044, 32'h0001_0082,
        32'h0000_A5C8, 32'h0002_5A18, 32'h0000_3358, 32'h0000_00C0};
    localparam logic [31:0] ADDR_T [7] = '{32'h10, 32'h00FF_FFFE, 32'h00AB_CDEF,
        32'h20, 32'h00FF_FFFF, 32'h1234, 32'h000F_0F0F};
    localparam logic [7:0] PRE_T [7] = '{8'h34, 8'hC9, 8'h00, 8'h34, 8'h0F, 8'hA6, 8'h00};
    localparam logic [6:0] CONT_T = 7'h18;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic wide = 1'b0;
    logic enh = 1'b0;
    logic [1:0] lc = 2'h0;
    logic pre_en = 1'b0;
    logic [7:0] pre = 8'h00;
    logic hold_n = 1'b1;
    wire logic hready;
    wire logic cont;
    wire logic hresp;
    wire logic frame_act;
    wire logic [31:0] hrdata;
    wire logic [31:0] rd_addr;
    wire logic [7:0] rd_data;
    logic [31:0] c, a, rd, e, m;
    int mismatches = 0;
    int check_count = 0;
    // array contents also show a carry past the top address
    function automatic logic [7:0] arr(input logic [31:0] x);
        return x[7:0] + x[23:16] + x[31:24] + 8'h11;
    endfunction
    assign rd_data = arr(rd_addr);
    sdfr_link_if link();
    sdfr_host sdfr_host_i (.I_CLK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .LINK(link));
    sdfr_mem sdfr_mem_i (.I_CLK(clk), .I_SRST(srst), .LINK(link),
        .I_WIDE_ADDRESS_SELECT(wide), .I_ENHANCED_LATENCY_TABLE(enh),
        .I_LATENCY_CODE_FIELD(lc), .I_LEARNING_PREAMBLE_EN(pre_en), .I_LEARNING_PREAMBLE(pre),
        .I_HOLD_N(hold_n), .O_RD_ADDR(rd_addr), .I_RD_DATA(rd_data), .O_CONT_MODE(cont),
        .O_FRAME_ACTIVE(frame_act));
    sdfr_link_sva sdfr_link_sva_i (.I_CLK(clk), .I_SRST(srst), .i_sck(link.sck),
        .i_cs_n(link.cs_n), .i_si_oe(link.si_oe), .i_so_drv(link.so_drv),
        .i_so_oe(link.so_oe));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // one single word transfer, read data taken at the end of the data phase
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        bus(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        for (int i = 0; i < 7; i++) begin
            c = CTRL_T[i];
            a = ADDR_T[i];
            @(posedge clk);
            wide <= c[2];
            enh <= c[3];
            lc <= c[7:6];
            pre_en <= PRE_T[i] != 8'h00;
            pre <= PRE_T[i];
            hold_n <= i[0];
            bus(1'b1, sdfr_pkg::REG_ADDR, a, rd);
            bus(1'b1, sdfr_pkg::REG_CTRL, c | 32'h1, rd);
            rd = 32'h0;
            for (int k = 0; k < 2000 && rd[1] !== 1'b1; k++) begin
                bus(1'b0, sdfr_pkg::REG_STATUS, 32'h0, rd);
            end
            chk("done", 32'h2, rd & 32'h2);
            if (PRE_T[i] != 8'h00) begin
                chk("preamble", {24'h0, PRE_T[i]}, {24'h0, rd[15:8]});
            end
            e = 32'h0;
            m = 32'h0;
            for (int b = 0; b <= int'(c[17:16]); b++) begin
                e = {e[23:0], arr(a)};
                m = {m[23:0], 8'hFF};
                a = (a == sdfr_pkg::ARRAY_TOP) ? 32'h0 : a + 32'h1;
            end
            bus(1'b0, sdfr_pkg::REG_RDATA, 32'h0, rd);
            chk("rdata", e, rd & m);
            chk("cont", {31'h0, CONT_T[i]}, {31'h0, cont});
            chk("frame idle", 32'h0, {31'h0, frame_act});
        end
        // go reads back as zero, reserved bits dropped
        bus(1'b0, sdfr_pkg::REG_CTRL, 32'h0, rd);
        chk("ctrl", (CTRL_T[6] | 32'h1) & sdfr_pkg::CTRL_MASK, rd);
        bus(1'b0, sdfr_pkg::REG_ADDR, 32'h0, rd);
        chk("addr", ADDR_T[6], rd);
        bus(1'b1, sdfr_pkg::REG_STATUS, 32'h2, rd);
        bus(1'b0, sdfr_pkg::REG_STATUS, 32'h0, rd);
        chk("done clear", 32'h0, rd & 32'h2);
        report_and_stop();
    end
endmodule
